// File: design/mil_pkg.sv
// Shared constants for the monitor interrupt logic
package mil_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] HW_TEMP_LIMIT_A_ADDR = 8'h13;
  localparam logic [7:0] HW_TEMP_LIMIT_B_ADDR = 8'h14;
  localparam logic [7:0] CHANNEL_MODE_ADDR = 8'h16;
  localparam logic [7:0] HW_TEMP_LIMIT_C_ADDR = 8'h17;
  localparam logic [7:0] HW_TEMP_LIMIT_D_ADDR = 8'h18;
  localparam logic [7:0] FAN_OUT_ADDR = 8'h19;
  localparam logic [7:0] FIRST_CONFIG_ADDR = 8'h40;
  localparam logic [7:0] STATUS_A_ADDR = 8'h41;
  localparam logic [7:0] STATUS_MIRROR_B_ADDR = 8'h42;
  localparam logic [7:0] STATUS_B_ADDR = 8'h43;
  localparam logic [7:0] MASK_A_ADDR = 8'h44;
  localparam logic [7:0] MASK_B_ADDR = 8'h45;
  localparam logic [7:0] INTRUSION_CLEAR_ADDR = 8'h46;
  localparam logic [7:0] SECOND_CONFIG_ADDR = 8'h4A;
  localparam logic [7:0] STATUS_MIRROR_A_ADDR = 8'h4C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG1_START_BIT = 0;
  localparam int CFG1_INT_EN_BIT = 1;
  localparam int CFG1_THERMAL_ALARM_N_EN_BIT = 2;
  localparam int CFG1_INT_CLR_BIT = 3;
  localparam int CFG1_THERMAL_ALARM_N_CLR_BIT = 6;
  localparam int CFG2_TEMP_MASK_BIT = 0;
  localparam int CFG2_ACPI_BIT = 3;
  localparam int CFG2_REQ_EN_LO_BIT = 6;
  localparam int CHMODE_REQ_EN_LO_BIT = 4;
  localparam int CHMODE_REQ_MODE_BIT = 7;
  localparam int INTRUSION_CLR_BIT = 7;
  localparam int STATUS_INTRUSION_IDX = 12;
  localparam int STATUS_THERMAL_ALARM_N_IDX = 13;

  // ----------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------
  localparam logic [7:0] FIRST_CONFIG_RST = 8'h08;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] HW_LIMIT_RST = 8'hFF;
  localparam logic [7:0] FAN_FULL = 8'hFF;
  localparam logic [15:0] TEMP_STATUS_BITS = 16'h2030;
  localparam logic [4:0] REQ_ACTIVE_LOW = 5'h07;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int INTRUSION_CLR_MS = 20;
  localparam int INTRUSION_CLR_CYCLES = INTRUSION_CLR_MS * (CLK_HZ / 1000);
  localparam int INTRUSION_CNT_W = 20;

  // Last comparison outcome of a temperature channel
  typedef enum logic [1:0] {
    MIL_IN_LIMIT,
    MIL_ABOVE,
    MIL_BELOW
  } mil_kind_t;

endpackage : mil_pkg

// File: design/mil_top.sv
// Interrupt logic of a system hardware monitor
// Functional notes
// [R1] Intrusion pin: active-high input, open-drain clear driver
// [R2] Intrusion interrupt held while external latch set
// [R3] Intrusion clear bit drives pin low 20 ms
// [R4] Each stored measurement sets or clears status bit
// [R5] Mask bit high blocks its status bit
// [R6] Unmasked status bits ORed onto interrupt pin
// [R7] Interrupt pin needs enable high, clear low
// [R8] Mode bit turns voltage-ID pins into requests
// [R9] Requests level-sensitive; first three active low
// [R10] Each request individually enabled by config bits
// [R11] Requests not latched; source must drop them
// [R12] Status read returns value then clears it
// [R13] Interrupt clear bit leaves status untouched
// [R14] Mirrors copy status updates, never cleared by reads
// [R15] Temperature over soft or hardware limit interrupts
// [R16] Cleared high alarm rearms only on new cause
// [R17] Cleared low alarm rearms only on new cause
// [R18] External thermal pin low sets thermal status
// [R19] Thermal output enable and mode select bits
// [R20] Config bit masks temperature from interrupt pin
// [R21] External thermal low forces fan output full
// [R22] Interrupt clear bit halts monitoring
// [R23] Interrupt and thermal pins only pull low
`timescale 1ns/1ps
`default_nettype none

module mil_top
  import mil_pkg::*;
#(
  parameter int INTRUSION_CYCLES = mil_pkg::INTRUSION_CLR_CYCLES,
  parameter int NUM_REQ = 5
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Measurement results
  input wire logic meas_valid_i,
  input wire logic [3:0] meas_index_i,
  input wire logic [7:0] meas_value_i,
  input wire logic [7:0] meas_hi_lim_i,
  input wire logic [7:0] meas_lo_lim_i,
  input wire logic meas_lim_new_i,
  input wire logic meas_temp_i,
  input wire logic [1:0] meas_hw_sel_i,
  output logic monitor_run_o,
  // Interrupt pin
  output logic int_pin_o,
  output logic int_pin_oe_o,
  // Thermal pin
  input wire logic thermal_alarm_n_i,
  output logic thermal_alarm_n_o,
  output logic thermal_alarm_n_oe_o,
  // Intrusion pin
  input wire logic intrusion_pin_i,
  output logic intrusion_pin_o,
  output logic intrusion_pin_oe_o,
  // Voltage-ID / request pins
  input wire logic [NUM_REQ-1:0] cpu_voltage_code_i,
  // Fan control
  output logic [7:0] fan_ctrl_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic mil_kind_t classify(input logic [7:0] v, input logic [7:0] hi,
                                         input logic [7:0] lo);
    if (v > hi) begin
      return MIL_ABOVE;
    end else if (v < lo) begin
      return MIL_BELOW;
    end
    return MIL_IN_LIMIT;
  endfunction : classify

  function automatic logic [7:0] hw_limit(input logic [1:0] sel, input logic [31:0] lims);
    return lims[sel*8 +: 8];
  endfunction : hw_limit

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] first_config, next_first_config;
  logic [7:0] second_config, next_second_config;
  logic [7:0] channel_mode, next_channel_mode;
  logic [31:0] hw_lims, next_hw_lims;
  logic [15:0] status, next_status;
  logic [15:0] mirror, next_mirror;
  logic [15:0] mask, next_mask;
  logic [7:0] fan_reg, next_fan_reg;
  logic [7:0] rdata, next_rdata;
  mil_kind_t kind [16];
  mil_kind_t next_kind [16];
  logic thermal_alarm_n_act, next_thermal_alarm_n_act;
  logic [INTRUSION_CNT_W-1:0] intr_cnt, next_intr_cnt;
  logic intr_clearing;
  logic thermal_alarm_n_ext;
  logic [NUM_REQ-1:0] req_en;
  logic [NUM_REQ-1:0] req_act;
  logic req_any;
  logic temp_hit;
  logic meas_ok;
  mil_kind_t new_kind;
  logic hw_over;
  logic [15:0] int_mask;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  always_comb begin
    intr_clearing = (intr_cnt != '0);
    // Our own drive also pulls the pin low, so only a foreign low counts
    thermal_alarm_n_ext = !thermal_alarm_n_i && !thermal_alarm_n_oe_o; // see [R18]
    // Monitoring pauses while the interrupt clear bit stands
    meas_ok = meas_valid_i && first_config[CFG1_START_BIT]
              && !first_config[CFG1_INT_CLR_BIT]; // see [R22]
    new_kind = classify(meas_value_i, meas_hi_lim_i, meas_lo_lim_i); // see [R4]
    hw_over = meas_temp_i && (meas_value_i > hw_limit(meas_hw_sel_i, hw_lims)); // see [R15]
    if (hw_over) begin
      new_kind = MIL_ABOVE; // see [R15]
    end
    for (int i = 0; i < NUM_REQ; i++) begin
      if (i < 3) begin
        req_en[i] = channel_mode[CHMODE_REQ_EN_LO_BIT + i]; // see [R10]
      end else begin
        req_en[i] = second_config[CFG2_REQ_EN_LO_BIT + i - 3]; // see [R10]
      end
      // Level only, nothing held: the source must drop it itself
      req_act[i] = (cpu_voltage_code_i[i] ^ REQ_ACTIVE_LOW[i]) && req_en[i]; // see [R9] [R11]
    end
    req_any = channel_mode[CHMODE_REQ_MODE_BIT] && (|req_act); // see [R8]
    int_mask = mask;
    if (second_config[CFG2_TEMP_MASK_BIT]) begin
      int_mask = mask | TEMP_STATUS_BITS; // see [R20]
    end
    temp_hit = meas_ok && meas_temp_i
               && ((second_config[CFG2_ACPI_BIT]) ? hw_over : (new_kind == MIL_ABOVE));
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_first_config = first_config;
    next_second_config = second_config;
    next_channel_mode = channel_mode;
    next_hw_lims = hw_lims;
    next_status = status;
    next_mirror = mirror;
    next_mask = mask;
    next_fan_reg = fan_reg;
    next_rdata = rdata;
    next_kind = kind;
    next_thermal_alarm_n_act = thermal_alarm_n_act;
    next_intr_cnt = intr_cnt;

    // Register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        HW_TEMP_LIMIT_A_ADDR: next_hw_lims[7:0] = reg_wdata_i;
        HW_TEMP_LIMIT_B_ADDR: next_hw_lims[15:8] = reg_wdata_i;
        HW_TEMP_LIMIT_C_ADDR: next_hw_lims[23:16] = reg_wdata_i;
        HW_TEMP_LIMIT_D_ADDR: next_hw_lims[31:24] = reg_wdata_i;
        CHANNEL_MODE_ADDR: next_channel_mode = reg_wdata_i;
        FAN_OUT_ADDR: next_fan_reg = reg_wdata_i;
        FIRST_CONFIG_ADDR: next_first_config = reg_wdata_i;
        SECOND_CONFIG_ADDR: next_second_config = reg_wdata_i;
        MASK_A_ADDR: next_mask[7:0] = reg_wdata_i;
        MASK_B_ADDR: next_mask[15:8] = reg_wdata_i;
        INTRUSION_CLEAR_ADDR: begin
          if (reg_wdata_i[INTRUSION_CLR_BIT]) begin
            next_intr_cnt = INTRUSION_CNT_W'(INTRUSION_CYCLES); // see [R3]
          end
        end
        default: ;
      endcase
    end else if (intr_clearing) begin
      next_intr_cnt = intr_cnt - 1'b1; // see [R3]
    end

    // Register reads, answered one cycle later
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        HW_TEMP_LIMIT_A_ADDR: next_rdata = hw_lims[7:0];
        HW_TEMP_LIMIT_B_ADDR: next_rdata = hw_lims[15:8];
        HW_TEMP_LIMIT_C_ADDR: next_rdata = hw_lims[23:16];
        HW_TEMP_LIMIT_D_ADDR: next_rdata = hw_lims[31:24];
        CHANNEL_MODE_ADDR: next_rdata = channel_mode;
        FAN_OUT_ADDR: next_rdata = fan_reg;
        FIRST_CONFIG_ADDR: next_rdata = first_config;
        SECOND_CONFIG_ADDR: next_rdata = second_config;
        MASK_A_ADDR: next_rdata = mask[7:0];
        MASK_B_ADDR: next_rdata = mask[15:8];
        INTRUSION_CLEAR_ADDR: next_rdata = {intr_clearing, 7'h00}; // see [R3]
        STATUS_A_ADDR: begin
          next_rdata = status[7:0];
          next_status[7:0] = 8'h00; // see [R12]
        end
        STATUS_B_ADDR: begin
          next_rdata = status[15:8];
          next_status[15:8] = 8'h00; // see [R12]
          if (!second_config[CFG2_ACPI_BIT]) begin
            next_thermal_alarm_n_act = 1'b0;
          end
        end
        STATUS_MIRROR_A_ADDR: next_rdata = mirror[7:0]; // see [R14]
        STATUS_MIRROR_B_ADDR: next_rdata = mirror[15:8]; // see [R14]
        default: next_rdata = 8'h00;
      endcase
    end

    // Measurement updates win over a clearing read in the same cycle
    if (meas_ok) begin
      if (meas_temp_i) begin
        next_kind[meas_index_i] = new_kind;
        if (new_kind == MIL_IN_LIMIT) begin
          next_status[meas_index_i] = 1'b0; // see [R4]
        end else if ((new_kind != kind[meas_index_i]) || meas_lim_new_i) begin
          // A cleared alarm stays quiet while the same side persists
          next_status[meas_index_i] = 1'b1; // see [R15] [R16] [R17]
        end
      end else begin
        next_status[meas_index_i] = (new_kind != MIL_IN_LIMIT); // see [R4]
      end
      next_mirror[meas_index_i] = next_status[meas_index_i]; // see [R14]
    end

    // Intrusion level holds its bit; the pin is ignored while we pull it
    if (intrusion_pin_i && !intr_clearing) begin
      next_status[STATUS_INTRUSION_IDX] = 1'b1; // see [R1] [R2]
      next_mirror[STATUS_INTRUSION_IDX] = 1'b1; // see [R14]
    end
    if (thermal_alarm_n_ext) begin
      next_status[STATUS_THERMAL_ALARM_N_IDX] = 1'b1; // see [R18]
      next_mirror[STATUS_THERMAL_ALARM_N_IDX] = 1'b1; // see [R14]
    end

    // Thermal alarm state
    if (first_config[CFG1_THERMAL_ALARM_N_CLR_BIT]) begin
      next_thermal_alarm_n_act = 1'b0; // see [R19]
    end else if (temp_hit) begin
      next_thermal_alarm_n_act = 1'b1; // see [R19]
    end else if (meas_ok && meas_temp_i) begin
      if (second_config[CFG2_ACPI_BIT] ? !hw_over : (new_kind == MIL_BELOW)) begin
        next_thermal_alarm_n_act = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_config <= FIRST_CONFIG_RST;
      second_config <= REG_RST;
      channel_mode <= REG_RST;
      hw_lims <= {4{HW_LIMIT_RST}};
      status <= '0;
      mirror <= '0;
      mask <= '0;
      fan_reg <= REG_RST;
      rdata <= REG_RST;
      kind <= '{default: MIL_IN_LIMIT};
      thermal_alarm_n_act <= 1'b0;
      intr_cnt <= '0;
    end else if (ce_i) begin
      first_config <= next_first_config;
      second_config <= next_second_config;
      channel_mode <= next_channel_mode;
      hw_lims <= next_hw_lims;
      status <= next_status;
      mirror <= next_mirror;
      mask <= next_mask;
      fan_reg <= next_fan_reg;
      rdata <= next_rdata;
      kind <= next_kind;
      thermal_alarm_n_act <= next_thermal_alarm_n_act;
      intr_cnt <= next_intr_cnt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    reg_rdata_o = rdata;
    monitor_run_o = first_config[CFG1_START_BIT] && !first_config[CFG1_INT_CLR_BIT]; // see [R22]
    // Mirrors are not part of this OR; status is untouched by the clear bit
    int_pin_o = 1'b0; // see [R23]
    int_pin_oe_o = first_config[CFG1_INT_EN_BIT] && !first_config[CFG1_INT_CLR_BIT]
                   && ((|(status & ~int_mask)) || req_any); // see [R5] [R6] [R7] [R13]
    thermal_alarm_n_o = 1'b0; // see [R23]
    thermal_alarm_n_oe_o = first_config[CFG1_THERMAL_ALARM_N_EN_BIT] && thermal_alarm_n_act; // see [R19]
    intrusion_pin_o = 1'b0; // see [R1]
    intrusion_pin_oe_o = intr_clearing; // see [R3]
    fan_ctrl_o = thermal_alarm_n_ext ? FAN_FULL : fan_reg; // see [R21]
  end

endmodule : mil_top

`default_nettype wire

// File: sim/mil_top_chk.sv
// Port assertions for the monitor interrupt logic
`timescale 1ns/1ps
`default_nettype none
module mil_top_chk
  import mil_pkg::*;
#(
  parameter int INTRUSION_CYCLES = 16,
  parameter int NUM_REQ = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Pins and outputs
  input wire logic monitor_run_o,
  input wire logic int_pin_o,
  input wire logic int_pin_oe_o,
  input wire logic thermal_alarm_n_i,
  input wire logic thermal_alarm_n_o,
  input wire logic thermal_alarm_n_oe_o,
  input wire logic intrusion_pin_o,
  input wire logic intrusion_pin_oe_o,
  input wire logic [NUM_REQ-1:0] cpu_voltage_code_i,
  input wire logic [7:0] fan_ctrl_o
);
  // ------
  // Shadow state
  // ------
  logic [7:0] cfg1, cfg2, chm;
  int cnt;
  logic wr_ok, int_ok;
  logic [4:0] req_on;
  assign wr_ok = ce_i && reg_wr_i;
  assign int_ok = cfg1[CFG1_INT_EN_BIT] && !cfg1[CFG1_INT_CLR_BIT];
  assign req_on = (5'(cpu_voltage_code_i) ^ REQ_ACTIVE_LOW) & {cfg2[7:6], chm[6:4]};
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg1 <= FIRST_CONFIG_RST;
      cfg2 <= REG_RST;
      chm <= REG_RST;
      cnt <= 0;
    end else begin
      if (wr_ok && reg_addr_i == FIRST_CONFIG_ADDR) cfg1 <= reg_wdata_i;
      if (wr_ok && reg_addr_i == SECOND_CONFIG_ADDR) cfg2 <= reg_wdata_i;
      if (wr_ok && reg_addr_i == CHANNEL_MODE_ADDR) chm <= reg_wdata_i;
      cnt <= intrusion_pin_oe_o ? cnt + 1 : 0;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_pins_low_only;
    int_pin_o == 1'b0 && thermal_alarm_n_o == 1'b0;
  endproperty
  a_pins_low_only: assert property (p_pins_low_only)
    else $error("pin driver not low");
  property p_intr_low; intrusion_pin_o == 1'b0; endproperty
  a_intr_low: assert property (p_intr_low)
    else $error("intrusion driver not low");
  property p_int_gate; int_pin_oe_o |-> int_ok; endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("interrupt pin active while disabled");
  property p_run; monitor_run_o == (cfg1[CFG1_START_BIT] && !cfg1[CFG1_INT_CLR_BIT]); endproperty
  a_run: assert property (p_run)
    else $error("monitor run level wrong");
  property p_intr_start;
    wr_ok && reg_addr_i == INTRUSION_CLEAR_ADDR && reg_wdata_i[7] |=> intrusion_pin_oe_o;
  endproperty
  a_intr_start: assert property (p_intr_start)
    else $error("intrusion clear pulse missing");
  // Restart writes stretch the pulse, so only a floor
  property p_intr_len; $fell(intrusion_pin_oe_o) |-> cnt >= INTRUSION_CYCLES; endproperty
  a_intr_len: assert property (p_intr_len)
    else $error("intrusion clear pulse short");
  property p_fan; (!thermal_alarm_n_i && !thermal_alarm_n_oe_o)[*3] |-> fan_ctrl_o == FAN_FULL;
  endproperty
  a_fan: assert property (p_fan)
    else $error("fan not forced full");
  property p_req; (chm[CHMODE_REQ_MODE_BIT] && int_ok && |req_on)[*3] |-> int_pin_oe_o;
  endproperty
  a_req: assert property (p_req)
    else $error("request not on interrupt pin");
  c_intr: cover property ($rose(intrusion_pin_oe_o));
  c_int: cover property ($rose(int_pin_oe_o));
  c_fan: cover property (fan_ctrl_o == FAN_FULL);
endmodule : mil_top_chk
bind mil_top mil_top_chk #(.INTRUSION_CYCLES(INTRUSION_CYCLES), .NUM_REQ(NUM_REQ)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .monitor_run_o(monitor_run_o),
  .int_pin_o(int_pin_o), .int_pin_oe_o(int_pin_oe_o), .thermal_alarm_n_i(thermal_alarm_n_i),
  .thermal_alarm_n_o(thermal_alarm_n_o), .thermal_alarm_n_oe_o(thermal_alarm_n_oe_o),
  .intrusion_pin_o(intrusion_pin_o), .intrusion_pin_oe_o(intrusion_pin_oe_o),
  .cpu_voltage_code_i(cpu_voltage_code_i), .fan_ctrl_o(fan_ctrl_o));
`default_nettype wire

// File: sim/mil_far_model.sv
// Far side: pulled-up pins and the battery intrusion latch
`timescale 1ns/1ps
`default_nettype none
module mil_far_model (
  // Clock
  input wire logic clk_i,
  // Block pin drives
  input wire logic int_oe_i,
  input wire logic thermal_alarm_n_oe_i,
  input wire logic intr_oe_i,
  // Scenario controls
  input wire logic intr_event_i,
  input wire logic thermal_alarm_n_ext_i,
  // Resolved pin levels
  output logic int_n_o,
  output logic thermal_alarm_n_n_o,
  output logic intr_o
);
  logic latched = 1'b0;
  // Pull-ups win unless a party pulls low
  assign int_n_o = !int_oe_i;
  assign thermal_alarm_n_n_o = !(thermal_alarm_n_oe_i || thermal_alarm_n_ext_i);
  // Latch lives on battery; only a low pin clears it
  always @(posedge clk_i) begin
    if (intr_oe_i) begin
      latched <= 1'b0;
    end else if (intr_event_i) begin
      latched <= 1'b1;
    end
  end
  assign intr_o = latched && !intr_oe_i;
endmodule : mil_far_model
`default_nettype wire

// File: sim/mil_top_test.sv
// Self-checking bench for the monitor interrupt logic
`timescale 1ns/1ps
`default_nettype none
module mil_top_test;
  import mil_pkg::*;
  localparam int INTR_CYC = 16;
  logic clk_i = 1'b0, rstn_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, mval = 8'h00, fan;
  logic wr = 1'b0, rd = 1'b0, mv = 1'b0, mtemp = 1'b0, ir_ev = 1'b0, th_ext = 1'b0;
  logic ce = 1'b1;
  logic [3:0] midx = 4'h0;
  logic [4:0] vid = 5'h07;
  logic int_oe, th_oe, ir_oe, int_n, th_n, ir_lvl;
  int errors = 0, total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  mil_top #(.INTRUSION_CYCLES(INTR_CYC), .NUM_REQ(5)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .meas_valid_i(mv), .meas_index_i(midx),
    .meas_value_i(mval), .meas_hi_lim_i(8'h80), .meas_lo_lim_i(8'h20), .meas_lim_new_i(1'b0),
    .meas_temp_i(mtemp), .meas_hw_sel_i(2'h0), .monitor_run_o(), .int_pin_o(),
    .int_pin_oe_o(int_oe), .thermal_alarm_n_i(th_n), .thermal_alarm_n_o(),
    .thermal_alarm_n_oe_o(th_oe), .intrusion_pin_i(ir_lvl), .intrusion_pin_o(),
    .intrusion_pin_oe_o(ir_oe), .cpu_voltage_code_i(vid), .fan_ctrl_o(fan));
  mil_far_model far (.clk_i(clk_i), .int_oe_i(int_oe), .thermal_alarm_n_oe_i(th_oe), .intr_oe_i(ir_oe),
    .intr_event_i(ir_ev), .thermal_alarm_n_ext_i(th_ext), .int_n_o(int_n), .thermal_alarm_n_n_o(th_n),
    .intr_o(ir_lvl));
  // ------
  // Tasks
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_reg
  task automatic meas(input logic [3:0] i, input logic [7:0] v, input logic t);
    @(posedge clk_i);
    midx <= i;
    mval <= v;
    mtemp <= t;
    mv <= 1'b1;
    @(posedge clk_i);
    mv <= 1'b0;
  endtask : meas
  // Pins may pass through synchronisers, so let a few edges settle
  task automatic pin(input logic [7:0] exp);
    repeat (3) @(posedge clk_i);
    #1 check({7'h00, int_n}, exp);
  endtask : pin
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // ------
  // Scenarios
  // ------
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_reg(FIRST_CONFIG_ADDR, FIRST_CONFIG_RST);
    rd_reg(HW_TEMP_LIMIT_A_ADDR, HW_LIMIT_RST);
    rd_reg(8'h7F, 8'h00);
    wr_reg(HW_TEMP_LIMIT_D_ADDR, 8'h5A);
    rd_reg(HW_TEMP_LIMIT_D_ADDR, 8'h5A);
    wr_reg(FIRST_CONFIG_ADDR, 8'h03);
    pin(8'h01);
    meas(4'h3, 8'hA0, 1'b0);
    pin(8'h00);
    rd_reg(STATUS_MIRROR_A_ADDR, 8'h08);
    rd_reg(STATUS_MIRROR_A_ADDR, 8'h08);
    rd_reg(STATUS_A_ADDR, 8'h08);
    rd_reg(STATUS_A_ADDR, 8'h00);
    pin(8'h01);
    wr_reg(MASK_A_ADDR, 8'h08);
    meas(4'h3, 8'hA0, 1'b0);
    pin(8'h01);
    wr_reg(MASK_A_ADDR, 8'h00);
    pin(8'h00);
    wr_reg(FIRST_CONFIG_ADDR, 8'h0B);
    pin(8'h01);
    rd_reg(STATUS_A_ADDR, 8'h08);
    meas(4'h3, 8'hA0, 1'b0);
    wr_reg(FIRST_CONFIG_ADDR, 8'h03);
    pin(8'h01);
    meas(4'h4, 8'hA0, 1'b1);
    pin(8'h00);
    rd_reg(STATUS_A_ADDR, 8'h10);
    meas(4'h4, 8'hA0, 1'b1);
    pin(8'h01);
    meas(4'h4, 8'h10, 1'b1);
    pin(8'h00);
    rd_reg(STATUS_A_ADDR, 8'h10);
    meas(4'h4, 8'h10, 1'b1);
    pin(8'h01);
    wr_reg(SECOND_CONFIG_ADDR, 8'h01);
    meas(4'h4, 8'hA0, 1'b1);
    pin(8'h01);
    wr_reg(SECOND_CONFIG_ADDR, 8'h00);
    pin(8'h00);
    rd_reg(STATUS_A_ADDR, 8'h10);
    @(posedge clk_i) ir_ev <= 1'b1;
    @(posedge clk_i) ir_ev <= 1'b0;
    pin(8'h00);
    wr_reg(INTRUSION_CLEAR_ADDR, 8'h80);
    rd_reg(INTRUSION_CLEAR_ADDR, 8'h80);
    for (int n = 0; ir_oe === 1'b1; n++) begin
      if (n > 4 * INTR_CYC) begin
        errors++;
        finish_test();
      end
      @(posedge clk_i);
    end
    rd_reg(INTRUSION_CLEAR_ADDR, 8'h00);
    rd_reg(STATUS_B_ADDR, 8'h10);
    pin(8'h01);
    @(posedge clk_i) th_ext <= 1'b1;
    pin(8'h00);
    check(fan, FAN_FULL);
    @(posedge clk_i) th_ext <= 1'b0;
    rd_reg(STATUS_B_ADDR, 8'h20);
    pin(8'h01);
    wr_reg(CHANNEL_MODE_ADDR, 8'hF0);
    wr_reg(SECOND_CONFIG_ADDR, 8'hC0);
    pin(8'h01);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i) vid <= 5'h07 ^ (5'h01 << i);
      pin(8'h00);
      @(posedge clk_i) vid <= 5'h07;
      pin(8'h01);
    end
    wr_reg(CHANNEL_MODE_ADDR, 8'h80);
    wr_reg(SECOND_CONFIG_ADDR, 8'h00);
    @(posedge clk_i) vid <= 5'h18;
    pin(8'h01);
    wr_reg(CHANNEL_MODE_ADDR, 8'h70);
    pin(8'h01);
    // Enable low freezes state, so a write then is lost
    @(posedge clk_i) ce <= 1'b0;
    wr_reg(MASK_B_ADDR, 8'h55);
    @(posedge clk_i) ce <= 1'b1;
    rd_reg(MASK_B_ADDR, 8'h00);
    finish_test();
  end
endmodule : mil_top_test
`default_nettype wire
